// ==== pkg/twbsp_pkg.sv ====
// Shared constants of the two-word burst SRAM port.
// Assumes one system clock that oversamples the external input clocks.
package twbsp_pkg;
    localparam int unsigned WORD_W         = 18;
    localparam int unsigned LANE_W         = 9;
    localparam int unsigned LANES_WORD     = 2;
    localparam int unsigned LANES_BURST    = 4;
    localparam int unsigned BURST_W        = 36;
    localparam int unsigned ADDR_W         = 21;
    localparam int unsigned LEGACY_MAX_MHZ = 167;
    localparam int unsigned SYS_CLK_MHZ    = 250;
    localparam logic [17:0] WORD_RST       = 18'h0_0000;
    localparam logic [35:0] BURST_RST      = 36'h0_0000_0000;
    localparam logic [3:0]  BE_RST         = 4'h0;
    localparam logic        OE_RST         = 1'b0;
    localparam logic        VALID_RST      = 1'b0;
endpackage

// ==== pkg/twbsp_mem_if.sv ====
// Carrier between the port sequencer and its burst memory.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface twbsp_mem_if #(
    parameter int unsigned AW = twbsp_pkg::ADDR_W
);
    logic [AW-1:0]                       wr_addr;
    logic [twbsp_pkg::BURST_W-1:0]       wr_data;
    logic [twbsp_pkg::LANES_BURST-1:0]   wr_be;
    logic                                wr_en;
    logic [AW-1:0]                       rd_addr;
    logic [twbsp_pkg::BURST_W-1:0]       rd_data;

    modport ctrl (output wr_addr, output wr_data, output wr_be, output wr_en,
                  output rd_addr, input rd_data);
    modport mem  (input wr_addr, input wr_data, input wr_be, input wr_en,
                  input rd_addr, output rd_data);
endinterface

// ==== src/twbsp_mem.sv ====
// Burst memory: two word arrays side by side, byte-lane writes.
// Assumes read address is steady for a cycle before data is used.
`timescale 1ns/1ps
module twbsp_mem (
    input  wire logic clock,
    twbsp_mem_if.mem  bus
);
    localparam int unsigned DEPTH = 1 << $bits(bus.rd_addr);

    logic [twbsp_pkg::BURST_W-1:0] array_q [DEPTH];

    // Lane 0/1 form the first word, lanes 2/3 the second word
    always_ff @(posedge clock) begin
        if (bus.wr_en) begin
            for (int i = 0; i < twbsp_pkg::LANES_BURST; i++) begin
                if (bus.wr_be[i]) begin
                    array_q[bus.wr_addr][i*twbsp_pkg::LANE_W +: twbsp_pkg::LANE_W] <=
                        bus.wr_data[i*twbsp_pkg::LANE_W +: twbsp_pkg::LANE_W];
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        bus.rd_data <= array_q[bus.rd_addr];
    end
endmodule

// ==== src/twbsp_top.sv ====
// Two-word burst SRAM port: pin-level sequencer for reads and writes.
// Assumes the input clock pair is far slower than clock and is oversampled.
//
// Contract
// - Echo clock pair follows the input clock pair, running continuously.
// - Low pll_disable_n selects legacy one-cycle latency mode, up to 167 MHz.
// - Read latency is 2.5 cycles with PLL on, one cycle with it off.
// - Accesses start only at a rising edge of the positive input clock.
// - Data captured and launched on rising edges of both input clocks.
// - Direction and load strobe sampled on positive clock rise, byte selects on both rises.
// - Each access moves two 18-bit words from two internal word arrays.
// - Read command: direction high, load strobe low; address latched for read.
// - PLL on: first read word on negative clock, second on following positive rise; PLL off: first on positive rise, second on negative.
// - A new read may be accepted on every positive clock rise.
// - On read deselect, finish bursts then tristate after next negative rise.
// - Write command: direction low, load strobe low; write address stored.
// - First write word captured on next positive rise, masked by byte selects.
// - Second write word captured on following negative rise, masked likewise.
// - Both halves captured, the 36-bit burst is committed at the address.
// - A write may be accepted on every positive rise, 18 bits per edge.
// - With writes deselected, pending writes complete and inputs are ignored.
// - Low load strobe defines a bus cycle; every transaction is two words.
// - Output valid flag aligned to echo clocks, half a cycle before data.
// - Last write is held in registers; same-address reads bypass the array.
`timescale 1ns/1ps
module twbsp_top #(
    parameter int unsigned ADDR_W = twbsp_pkg::ADDR_W
) (
    input  wire logic                      clock,
    input  wire logic                      reset,
    input  wire logic                      in_clk,
    input  wire logic                      in_clk_n,
    input  wire logic                      pll_disable_n,
    input  wire logic                      load_strobe_n,
    input  wire logic                      access_dir,
    input  wire logic [1:0]                byte_write_sel_n,
    input  wire logic [ADDR_W-1:0]         address,
    input  wire logic [17:0]               dq_in,
    output logic      [17:0]               dq_out,
    output logic                           dq_oe,
    output logic                           echo_edge_ref,
    output logic                           echo_edge_ref_n,
    output logic                           output_valid_flag
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: every pin passes two flops before any logic reads it

    localparam int unsigned SW = 1 + 1 + 1 + 1 + 1 + 2 + ADDR_W + 18;

    logic [SW-1:0] pins_raw;
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    logic          k_prev_q;
    logic          kn_prev_q;

    assign pins_raw = {in_clk, in_clk_n, pll_disable_n, load_strobe_n, access_dir,
                       byte_write_sel_n, address, dq_in};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    logic              k_s;
    logic              kn_s;
    logic              pll_on_s;
    logic              ld_n_s;
    logic              dir_s;
    logic [1:0]        bws_n_s;
    logic [ADDR_W-1:0] addr_s;
    logic [17:0]       din_s;

    assign {k_s, kn_s, pll_on_s, ld_n_s, dir_s, bws_n_s, addr_s, din_s} = sync2_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            k_prev_q  <= 1'b0;
            kn_prev_q <= 1'b0;
        end else begin
            k_prev_q  <= k_s;
            kn_prev_q <= kn_s;
        end
    end

    logic k_rise;
    logic kn_rise;

    assign k_rise  = k_s & ~k_prev_q;
    assign kn_rise = kn_s & ~kn_prev_q;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Picks held lanes where the posted write enabled them, else array lanes
    function automatic logic [17:0] merge_word(input logic [17:0] arr,
                                               input logic [17:0] held,
                                               input logic [1:0]  be);
        logic [17:0] r;
        r = arr;
        for (int i = 0; i < 2; i++) begin
            if (be[i]) begin
                r[i*twbsp_pkg::LANE_W +: twbsp_pkg::LANE_W] =
                    held[i*twbsp_pkg::LANE_W +: twbsp_pkg::LANE_W];
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Command decode at positive clock rise

    logic rd_cmd;
    logic wr_cmd;

    assign rd_cmd = k_rise & ~ld_n_s & dir_s;
    assign wr_cmd = k_rise & ~ld_n_s & ~dir_s;

    ////////////////////////////////////////////////////////////////////////////
    // Read pipeline: one slot per positive rise, accepts every rise

    logic              s1_v_q, s2_v_q, s3_v_q;
    logic [ADDR_W-1:0] s1_a_q, s2_a_q, s3_a_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_v_q <= 1'b0;
            s2_v_q <= 1'b0;
            s3_v_q <= 1'b0;
            s1_a_q <= '0;
            s2_a_q <= '0;
            s3_a_q <= '0;
        end else if (k_rise) begin
            s1_v_q <= rd_cmd;
            s1_a_q <= addr_s;
            s2_v_q <= s1_v_q;
            s2_a_q <= s1_a_q;
            s3_v_q <= s2_v_q;
            s3_a_q <= s2_a_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: address on command, halves on next rise pair, then commit

    logic              wr_ph_q;
    logic              wr_ph2_q;
    logic [ADDR_W-1:0] wr_cmd_a_q;
    logic [ADDR_W-1:0] held_a_q;
    logic [35:0]       held_d_q;
    logic [3:0]        held_be_q;
    logic              held_v_q;
    logic              commit_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ph_q    <= 1'b0;
            wr_cmd_a_q <= '0;
        end else if (k_rise) begin
            wr_ph_q <= wr_cmd;
            if (wr_cmd) begin
                wr_cmd_a_q <= addr_s;
            end
        end
    end

    // Held write stays until the next write's data phase, so reads can bypass
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wr_ph2_q  <= 1'b0;
            held_a_q  <= '0;
            held_d_q  <= twbsp_pkg::BURST_RST;
            held_be_q <= twbsp_pkg::BE_RST;
            held_v_q  <= 1'b0;
            commit_q  <= 1'b0;
        end else begin
            commit_q <= 1'b0;
            if (k_rise) begin
                wr_ph2_q <= wr_ph_q;
                if (wr_ph_q) begin
                    held_a_q       <= wr_cmd_a_q;
                    held_d_q[17:0] <= din_s;
                    held_be_q      <= {2'b00, ~bws_n_s};
                    held_v_q       <= 1'b1;
                end
            end else if (kn_rise && wr_ph2_q) begin
                wr_ph2_q        <= 1'b0;
                held_d_q[35:18] <= din_s;
                held_be_q[3:2]  <= ~bws_n_s;
                commit_q        <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Burst memory

    twbsp_mem_if #(.AW(ADDR_W)) mem_bus ();

    // Address read ahead of the launch edge; latency hides inside the half cycle
    assign mem_bus.rd_addr = pll_on_s ? s3_a_q : s1_a_q;
    assign mem_bus.wr_addr = held_a_q;
    assign mem_bus.wr_data = held_d_q;
    assign mem_bus.wr_be   = held_be_q;
    assign mem_bus.wr_en   = commit_q;

    twbsp_mem u_mem (
        .clock (clock),
        .bus   (mem_bus)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Output launch

    logic        w0_go;
    logic        w1_go;
    logic        bypass;
    logic [35:0] burst_now;
    logic [17:0] word1_q;

    // PLL on: word 0 on negative rise after slot 3 fills, word 1 on next rise
    // PLL off: word 0 on the next positive rise, word 1 on the negative rise
    always_comb begin
        if (pll_on_s) begin
            w0_go = kn_rise & s3_v_q;
            w1_go = k_rise & s3_v_q;
        end else begin
            w0_go = k_rise & s1_v_q;
            w1_go = kn_rise & s2_v_q;
        end
    end

    assign bypass = held_v_q & (held_a_q == mem_bus.rd_addr);
    assign burst_now = bypass ?
        {merge_word(mem_bus.rd_data[35:18], held_d_q[35:18], held_be_q[3:2]),
         merge_word(mem_bus.rd_data[17:0], held_d_q[17:0], held_be_q[1:0])} :
        mem_bus.rd_data;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dq_out  <= twbsp_pkg::WORD_RST;
            word1_q <= twbsp_pkg::WORD_RST;
        end else if (w0_go) begin
            dq_out  <= burst_now[17:0];
            word1_q <= burst_now[35:18];
        end else if (w1_go) begin
            dq_out  <= word1_q;
        end
    end

    // Released only on a negative rise with no word launched
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            dq_oe <= twbsp_pkg::OE_RST;
        end else if (w0_go || w1_go) begin
            dq_oe <= 1'b1;
        end else if (kn_rise) begin
            dq_oe <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Echo clocks and valid flag, both retimed on the same flop stage

    logic next_word;

    // True when a word will launch on the following input clock edge
    always_comb begin
        if (pll_on_s) begin
            next_word = k_rise ? s2_v_q : s3_v_q;
        end else begin
            next_word = k_rise ? s1_v_q : s1_v_q;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            echo_edge_ref     <= 1'b0;
            echo_edge_ref_n   <= 1'b0;
            output_valid_flag <= twbsp_pkg::VALID_RST;
        end else begin
            echo_edge_ref   <= k_s;
            echo_edge_ref_n <= kn_s;
            if (k_rise || kn_rise) begin
                output_valid_flag <= next_word;
            end
        end
    end

endmodule

// ==== test/twbsp_chk.sv ====
// Pin checker: echo clocks, valid flag, output enable.
// Assumes input clocks far slower than clock.
`timescale 1ns/1ps
module twbsp_chk (
    input wire logic        clock,
    input wire logic        reset,
    input wire logic        in_clk,
    input wire logic        in_clk_n,
    input wire logic        load_strobe_n,
    input wire logic        access_dir,
    input wire logic [17:0] dq_out,
    input wire logic        dq_oe,
    input wire logic        echo_edge_ref,
    input wire logic        echo_edge_ref_n,
    input wire logic        output_valid_flag
);
    logic [7:0] rd_age_q;
    logic [7:0] edge_age_q;
    logic [7:0] echo_age_q;
////////////////////////////////////////
    // Ages saturate so a quiet bus never looks young again
    always_ff @(posedge clock or posedge reset) begin
        if (reset) rd_age_q <= 8'hff;
        else if ($rose(in_clk) && !load_strobe_n && access_dir) rd_age_q <= 8'h00;
        else if (rd_age_q != 8'hff) rd_age_q <= rd_age_q + 8'h01;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) edge_age_q <= 8'h00;
        else if ($rose(in_clk) || $rose(in_clk_n)) edge_age_q <= 8'h00;
        else if (edge_age_q != 8'hff) edge_age_q <= edge_age_q + 8'h01;
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) echo_age_q <= 8'h00;
        else if ($changed(echo_edge_ref)) echo_age_q <= 8'h00;
        else if (echo_age_q != 8'hff) echo_age_q <= echo_age_q + 8'h01;
    end
////////////////////////////////////////
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    sequence k_rise_s; $rose(in_clk); endsequence
    sequence kn_rise_s; $rose(in_clk_n); endsequence
    sequence oe_on_s; $rose(dq_oe); endsequence
    echo_follow_a: assert property (k_rise_s |-> ##[1:6] $rose(echo_edge_ref))
        else $error("echo lagged input clock");
    echo_n_follow_a: assert property (kn_rise_s |-> ##[1:6] $rose(echo_edge_ref_n))
        else $error("echo n lagged input clock");
    echo_run_a: assert property (echo_age_q <= 8'h18)
        else $error("echo stopped");
    reset_quiet_a: assert property ($fell(reset) |-> !dq_oe && !output_valid_flag)
        else $error("outputs active after reset");
    valid_lead_a: assert property (oe_on_s |-> output_valid_flag && $past(output_valid_flag, 8))
        else $error("drive without valid lead");
    read_cause_a: assert property (oe_on_s |-> rd_age_q <= 8'h64)
        else $error("drive without read");
    quiet_off_a: assert property (rd_age_q > 8'h8c |-> !dq_oe)
        else $error("drive long after reads");
    oe_release_a: assert property ($fell(dq_oe) |-> in_clk_n && edge_age_q <= 8'h08)
        else $error("release off negative edge");
    launch_edge_a: assert property ($changed(dq_out) |-> edge_age_q <= 8'h08)
        else $error("data launched off edge");
    valid_edge_a: assert property ($changed(output_valid_flag) |-> edge_age_q <= 8'h08)
        else $error("valid moved off edge");
endmodule

bind twbsp_top twbsp_chk u_chk (.clock(clock), .reset(reset), .in_clk(in_clk),
    .in_clk_n(in_clk_n), .load_strobe_n(load_strobe_n), .access_dir(access_dir),
    .dq_out(dq_out), .dq_oe(dq_oe), .echo_edge_ref(echo_edge_ref),
    .echo_edge_ref_n(echo_edge_ref_n), .output_valid_flag(output_valid_flag));

// ==== test/twbsp_ctl_model.sv ====
// Controller model: input clock pair, commands, write data.
// Assumes the port samples pins within five clocks of an edge.
`timescale 1ns/1ps
module twbsp_ctl_model #(
    parameter int unsigned AW = 8
) (
    input  wire logic          clock,
    output logic               in_clk,
    output logic               in_clk_n,
    output logic               load_strobe_n,
    output logic               access_dir,
    output logic [1:0]         byte_write_sel_n,
    output logic [AW-1:0]      address,
    output logic [17:0]        dq_in,
    input  wire logic [17:0]   dq_out,
    input  wire logic          dq_oe
);
    logic [40:0] p1;
    logic [40:0] p2;
    initial begin
        load_strobe_n = 1'b1;
        access_dir = 1'b1;
        byte_write_sel_n = 2'h3;
        address = '0;
        dq_in = 18'h0_0000;
        p1 = '0;
        p2 = '0;
    end
////////////////////////////////////////
    // Free running pair, 125 ns period
    initial begin
        in_clk = 1'b0;
        forever #62.5 in_clk = ~in_clk;
    end
    assign in_clk_n = ~in_clk;
    // Pins change seven clocks after an edge; commands held a whole cycle, data half
    task automatic kcycle(input logic ld_n, input logic dir, input logic [AW-1:0] a,
                          input logic [17:0] d0, input logic [17:0] d1, input logic [3:0] be,
                          output logic [18:0] qn, output logic [18:0] qk);
        load_strobe_n <= ld_n;
        access_dir <= dir;
        address <= a;
        // Idle data is inverted so a stale word never looks valid
        dq_in <= p2[40] ? p2[21:4] : ~dq_in;
        byte_write_sel_n <= p2[40] ? p2[1:0] : 2'h3;
        @(posedge in_clk_n);
        repeat (6) @(posedge clock);
        #1 qn = {dq_oe, dq_out};
        @(posedge clock);
        dq_in <= p1[40] ? p1[39:22] : ~dq_in;
        byte_write_sel_n <= p1[40] ? p1[3:2] : 2'h3;
        @(posedge in_clk);
        repeat (6) @(posedge clock);
        #1 qk = {dq_oe, dq_out};
        p2 = p1;
        p1 = {!ld_n && !dir, d0, d1, be};
        @(posedge clock);
    endtask
endmodule

// ==== test/twbsp_tb_top.sv ====
// Bench for the burst port: controller model on the pins, timed read-back.
// Assumes the controller model and bound checker are compiled first.
`timescale 1ns/1ps
module twbsp_tb_top;
    localparam int unsigned AW = 8;
    logic          clock;
    logic          reset;
    logic          pll_disable_n;
    logic          in_clk;
    logic          in_clk_n;
    logic          load_strobe_n;
    logic          access_dir;
    logic [1:0]    byte_write_sel_n;
    logic [AW-1:0] address;
    logic [17:0]   dq_in;
    logic [17:0]   dq_out;
    logic          dq_oe;
    logic          echo_edge_ref;
    logic          echo_edge_ref_n;
    logic          output_valid_flag;
    logic [18:0]   qn [0:63];
    logic [18:0]   qk [0:63];
    int            n;
    int            fails;
    int            compares;
    twbsp_top #(.ADDR_W(AW)) dut (.clock(clock), .reset(reset), .in_clk(in_clk),
        .in_clk_n(in_clk_n), .pll_disable_n(pll_disable_n), .load_strobe_n(load_strobe_n),
        .access_dir(access_dir), .byte_write_sel_n(byte_write_sel_n), .address(address),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .echo_edge_ref(echo_edge_ref),
        .echo_edge_ref_n(echo_edge_ref_n), .output_valid_flag(output_valid_flag));
    twbsp_ctl_model #(.AW(AW)) ctl (.clock(clock), .in_clk(in_clk), .in_clk_n(in_clk_n),
        .load_strobe_n(load_strobe_n), .access_dir(access_dir),
        .byte_write_sel_n(byte_write_sel_n), .address(address), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe));
////////////////////////////////////////
    task automatic check(input string what, input logic [18:0] seen, input logic [18:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Samples: {oe, data} after each negative and positive edge of the call
    task automatic op(input logic ld_n, input logic dir, input logic [AW-1:0] a,
                      input logic [17:0] d0, input logic [17:0] d1, input logic [3:0] be);
        ctl.kcycle(ld_n, dir, a, d0, d1, be, qn[n], qk[n]);
        n++;
    endtask
    task automatic nop(input int k);
        repeat (k) op(1'b1, 1'b1, '0, 18'h0_0000, 18'h0_0000, 4'hf);
    endtask
    task automatic rd(input logic [AW-1:0] a);
        op(1'b0, 1'b1, a, 18'h0_0000, 18'h0_0000, 4'hf);
    endtask
    task automatic t_idle();
        nop(3);
        check("idle", qk[n-1], 19'h0_0000);
        $display("test idle done");
    endtask
    task automatic t_pipe();
        int i;
        i = n;
        op(1'b0, 1'b0, 8'h10, 18'h1_1111, 18'h2_2222, 4'h0);
        op(1'b0, 1'b0, 8'h20, 18'h3_3333, 18'h0_4444, 4'h0);
        rd(8'h20);
        rd(8'h10);
        // Two idle cycles at least before any write after reads; no read is cut short
        nop(4);
        check("early oe", {qn[i+4][18], 18'h0_0000}, 19'h0_0000);
        check("bypass w0", qn[i+5], {1'b1, 18'h3_3333});
        check("bypass w1", qk[i+5], {1'b1, 18'h0_4444});
        check("array w0", qn[i+6], {1'b1, 18'h1_1111});
        check("array w1", qk[i+6], {1'b1, 18'h2_2222});
        check("release", {qn[i+7][18], 18'h0_0000}, 19'h0_0000);
        $display("test pipe done");
    endtask
    task automatic t_mask();
        int i;
        i = n;
        op(1'b0, 1'b0, 8'h30, 18'h1_5555, 18'h2_6666, 4'h0);
        op(1'b0, 1'b0, 8'h30, 18'h3_ffff, 18'h3_ffff, 4'h9);
        rd(8'h30);
        nop(4);
        check("lane w0", qn[i+5], {1'b1, 18'h1_55ff});
        check("lane w1", qk[i+5], {1'b1, 18'h3_fe66});
        $display("test mask done");
    endtask
    task automatic t_legacy();
        int i;
        @(posedge clock);
        pll_disable_n <= 1'b0;
        nop(2);
        i = n;
        rd(8'h10);
        nop(3);
        check("legacy w0", qk[i+1], {1'b1, 18'h1_1111});
        check("legacy w1", qn[i+2], {1'b1, 18'h2_2222});
        check("legacy off", {qn[i+3][18], 18'h0_0000}, 19'h0_0000);
        @(posedge clock);
        pll_disable_n <= 1'b1;
        $display("test legacy done");
    endtask
    task automatic wrap_up();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    initial begin
        reset = 1'b1;
        pll_disable_n = 1'b1;
        n = 0;
        fails = 0;
        compares = 0;
        repeat (8) @(posedge clock);
        reset <= 1'b0;
        @(posedge in_clk);
        repeat (6) @(posedge clock);
        t_idle();
        t_pipe();
        t_mask();
        t_legacy();
        wrap_up();
    end
    // About twenty-five input cycles are needed; allow several times that
    initial begin
        #20000;
        fails++;
        wrap_up();
    end
endmodule
